//--- verilog/ghm_consts.svh
// Constants of the gyro health monitor: offsets, field positions, reset values, timing.
// Assumes a 40 MHz pclk; included by the package and by the design modules.
//
// Overview of operation
// - All health checks, each against its limit, merge into one health line.
// - Any failing check drives the health line low.
// - Power-up parity check of calibration memory; a word with an odd count of bad bits fails health.
// - Power-up check of every trim conversion; a wrong one fails health.
// - Drive demanded by the gain loop above its upper limit fails health.
// - Gain loop level below its lower limit fails health.
// - Health stays low at start-up until the drive loops have settled.
// - Rate demodulator saturation fails health.
// - Excessive demodulated quadrature magnitude fails health.
// - Serial message checksum is checked; failure is a reply flag only.
// - Active self-test adds an offset worth 150 deg/s to the rate output.
// - While self-test is enabled the health line is held low.
// - Analogue mode: self-test pin low enables, high disables.
// - Digital mode: command bit 6 set enables self-test, clear disables it.
// - Status fail bit set during self-test and whenever a check fails.
// - Bad checksum sets status bit 4, message ignored, last command kept.
`ifndef GHM_CONSTS_SVH
`define GHM_CONSTS_SVH

`define GHM_MON_W          12
`define GHM_RATE_W         16
`define GHM_CLK_NS         25
`define GHM_SETTLE_NS      100000
`define GHM_SETTLE_CYC     ((`GHM_SETTLE_NS + `GHM_CLK_NS - 1) / `GHM_CLK_NS)
`define GHM_TRIM_WAIT      4
`define GHM_ST_RATE_DPS    150
`define GHM_LSB_PER_DPS    16
`define GHM_MSG_BYTES      6

`define GHM_REG_STATUS     8'h00
`define GHM_REG_DRIVE_HI   8'h04
`define GHM_REG_LEVEL_LO   8'h08
`define GHM_REG_DEMOD_MAX  8'h0c
`define GHM_REG_QUAD_MAX   8'h10
`define GHM_REG_CMD        8'h14

`define GHM_RST_DRIVE_HI   12'hf00
`define GHM_RST_LEVEL_LO   12'h100
`define GHM_RST_DEMOD_MAX  12'hfc0
`define GHM_RST_QUAD_MAX   12'h400

`define GHM_CMD_TEST_BIT   6
`define GHM_ST_CODE_OK     3'h1
`define GHM_ST_TYPE_RATE   2'h0

`endif

//--- verilog/ghm_pkg.sv
// Types of the gyro health monitor.
// Assumes ghm_consts.svh is on the include path.
`include "ghm_consts.svh"

package ghm_pkg;

    // Monitor words from the analogue front end, all on pclk.
    typedef struct packed {
        logic [`GHM_MON_W-1:0] agc_drive;
        logic [`GHM_MON_W-1:0] agc_level;
        logic [`GHM_MON_W-1:0] demod_amp;
        logic [`GHM_MON_W-1:0] quad_amp;
    } ghm_mon_s;

    // Status byte of the serial reply, bit 7 first.
    typedef struct packed {
        logic       fail;
        logic [1:0] msg_type;
        logic       bad_prev;
        logic       test_on;
        logic [2:0] code;
    } ghm_status_s;

    typedef enum logic [4:0] {
        BOOT_READ  = 5'b00001,
        BOOT_CHECK = 5'b00010,
        BOOT_WAIT  = 5'b00100,
        BOOT_NEXT  = 5'b01000,
        BOOT_DONE  = 5'b10000
    } ghm_boot_e;

endpackage : ghm_pkg

//--- verilog/ghm_boot_check.sv
// Power-up walk over calibration memory: parity check and trim conversion check.
// Assumes the memory answers one cycle after cal_rd and the trim echo settles in
// GHM_TRIM_WAIT cycles after trim_load.
`timescale 1ns/1ps
`include "ghm_consts.svh"

module ghm_boot_check #(
    parameter int CAL_DEPTH = 16,
    parameter int CAL_W     = 8
) (
    // Clock and reset.
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // Calibration memory.
    output logic                              cal_rd,
    output logic [$clog2(CAL_DEPTH)-1:0]      cal_addr,
    input  wire logic [CAL_W:0]               cal_word,
    // Trim converter.
    output logic                              trim_load,
    output logic [CAL_W-1:0]                  trim_code,
    input  wire logic [CAL_W-1:0]             trim_echo,
    // Results.
    output logic                              done,
    output logic                              parity_fault,
    output logic                              trim_fault
);

    generate
        if (CAL_DEPTH < 2 || CAL_W < 1) begin : g_bad_cfg
            $error("ghm_boot_check: CAL_DEPTH must be 2 or more and CAL_W 1 or more");
        end
    endgenerate

    ghm_pkg::ghm_boot_e state;
    logic [2:0]         wait_cnt;

    assign cal_rd = (state == ghm_pkg::BOOT_READ);
    assign done   = (state == ghm_pkg::BOOT_DONE);

    // ==========================================================
    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ghm_pkg::BOOT_READ;
            cal_addr  <= '0;
            wait_cnt  <= 3'h0;
            trim_load <= 1'b0;
            trim_code <= '0;
        end else begin
            trim_load <= 1'b0;
            unique case (state)
                ghm_pkg::BOOT_READ: begin
                    state <= ghm_pkg::BOOT_CHECK;
                end
                ghm_pkg::BOOT_CHECK: begin
                    trim_code <= cal_word[CAL_W-1:0];
                    trim_load <= 1'b1;
                    wait_cnt  <= 3'(`GHM_TRIM_WAIT);
                    state     <= ghm_pkg::BOOT_WAIT;
                end
                ghm_pkg::BOOT_WAIT: begin
                    wait_cnt <= wait_cnt - 3'h1;
                    if (wait_cnt == 3'h1) begin
                        state <= ghm_pkg::BOOT_NEXT;
                    end
                end
                ghm_pkg::BOOT_NEXT: begin
                    cal_addr <= cal_addr + 1'b1;
                    if (cal_addr == ($clog2(CAL_DEPTH))'(CAL_DEPTH - 1)) begin
                        state <= ghm_pkg::BOOT_DONE;
                    end else begin
                        state <= ghm_pkg::BOOT_READ;
                    end
                end
                ghm_pkg::BOOT_DONE: begin
                    state <= ghm_pkg::BOOT_DONE;
                end
            endcase
        end
    end

    // ==========================================================
    // Latched faults, cleared only by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parity_fault <= 1'b0;
            trim_fault   <= 1'b0;
        end else begin
            if (state == ghm_pkg::BOOT_CHECK && ^cal_word) begin
                parity_fault <= 1'b1;
            end
            if (state == ghm_pkg::BOOT_NEXT && trim_echo != trim_code) begin
                trim_fault <= 1'b1;
            end
        end
    end

endmodule : ghm_boot_check

//--- verilog/ghm_monitor.sv
// Health monitor top: merges checks into one health line, runs self-test, checks
// serial command checksums and builds the status byte; limits over APB.
// Assumes monitor words, rate and serial bytes arrive on pclk; the self-test
// request pin and the mode pin are asynchronous.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`include "ghm_consts.svh"

module ghm_monitor #(
    parameter int SETTLE_CYC  = `GHM_SETTLE_CYC,
    parameter int CAL_DEPTH   = 16,
    parameter int CAL_W       = 8,
    parameter int LSB_PER_DPS = `GHM_LSB_PER_DPS
) (
    // Clock and reset.
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // APB slave.
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic [31:0]                       prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Pins.
    input  wire logic                         test_req_n,
    input  wire logic                         digital_mode,
    output logic                              health_ok,
    // Analogue monitors and rate path.
    input  wire ghm_pkg::ghm_mon_s            mon,
    input  wire logic                         demod_sat,
    input  wire logic [`GHM_RATE_W-1:0]       rate_in,
    output logic [`GHM_RATE_W-1:0]            rate_out,
    // Serial command bytes.
    input  wire logic                         msg_start,
    input  wire logic                         msg_byte_valid,
    input  wire logic [7:0]                   msg_byte,
    output ghm_pkg::ghm_status_s              status_byte,
    // Calibration memory and trim converter.
    output logic                              cal_rd,
    output logic [$clog2(CAL_DEPTH)-1:0]      cal_addr,
    input  wire logic [CAL_W:0]               cal_word,
    output logic                              trim_load,
    output logic [CAL_W-1:0]                  trim_code,
    input  wire logic [CAL_W-1:0]             trim_echo
);

    localparam int OFFSET = `GHM_ST_RATE_DPS * LSB_PER_DPS;

    generate
        if (SETTLE_CYC < 1 || SETTLE_CYC > 65535 || OFFSET >= 32768) begin : g_bad_cfg
            $error("ghm_monitor: SETTLE_CYC or self-test offset out of range");
        end
    endgenerate

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // Pin synchronisers
    logic [1:0] test_sync;
    logic [1:0] mode_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_sync <= 2'h3;
            mode_sync <= 2'h0;
        end else begin
            test_sync <= {test_sync[0], test_req_n};
            mode_sync <= {mode_sync[0], digital_mode};
        end
    end

    // ==========================================================
    // Power-up checks
    logic boot_done;
    logic parity_fault;
    logic trim_fault;

    ghm_boot_check #(
        .CAL_DEPTH (CAL_DEPTH),
        .CAL_W     (CAL_W)
    ) u_boot (
        .pclk         (pclk),
        .presetn      (presetn),
        .cal_rd       (cal_rd),
        .cal_addr     (cal_addr),
        .cal_word     (cal_word),
        .trim_load    (trim_load),
        .trim_code    (trim_code),
        .trim_echo    (trim_echo),
        .done         (boot_done),
        .parity_fault (parity_fault),
        .trim_fault   (trim_fault)
    );

    // ==========================================================
    // Limit registers
    logic [`GHM_MON_W-1:0] drive_hi;
    logic [`GHM_MON_W-1:0] level_lo;
    logic [`GHM_MON_W-1:0] demod_max;
    logic [`GHM_MON_W-1:0] quad_max;
    logic                  wr_en;

    assign wr_en = psel && penable && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_hi  <= `GHM_RST_DRIVE_HI;
            level_lo  <= `GHM_RST_LEVEL_LO;
            demod_max <= `GHM_RST_DEMOD_MAX;
            quad_max  <= `GHM_RST_QUAD_MAX;
        end else if (wr_en) begin
            unique case (paddr)
                `GHM_REG_DRIVE_HI:  drive_hi  <= pwdata[`GHM_MON_W-1:0];
                `GHM_REG_LEVEL_LO:  level_lo  <= pwdata[`GHM_MON_W-1:0];
                `GHM_REG_DEMOD_MAX: demod_max <= pwdata[`GHM_MON_W-1:0];
                `GHM_REG_QUAD_MAX:  quad_max  <= pwdata[`GHM_MON_W-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Continuous checks and loop settling
    logic        drive_high;
    logic        level_low;
    logic        sat_fail;
    logic        quad_fail;
    logic        settled;
    logic [15:0] settle_cnt;

    assign drive_high = mon.agc_drive > drive_hi;
    assign level_low  = mon.agc_level < level_lo;
    assign sat_fail   = demod_sat || (mon.demod_amp > demod_max);
    assign quad_fail  = mon.quad_amp > quad_max;

    // Loops count as settled only after SETTLE_CYC unbroken in-window cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= 16'h0;
            settled    <= 1'b0;
        end else if (!settled) begin
            if (!boot_done || drive_high || level_low) begin
                settle_cnt <= 16'h0;
            end else if (settle_cnt == 16'(SETTLE_CYC - 1)) begin
                settled <= 1'b1;
            end else begin
                settle_cnt <= settle_cnt + 16'h1;
            end
        end
    end

    // ==========================================================
    // Serial command intake and checksum
    logic [7:0] cmd;
    logic [7:0] cmd_new;
    logic [7:0] sum;
    logic [2:0] byte_idx;
    logic       bad_prev;
    logic       last_byte;
    logic       sum_ok;

    assign last_byte = msg_byte_valid && byte_idx == 3'(`GHM_MSG_BYTES - 1);
    assign sum_ok    = msg_byte == ~sum;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_idx <= 3'h0;
            sum      <= 8'h00;
            cmd_new  <= 8'h00;
        end else if (msg_start) begin
            byte_idx <= 3'h0;
            sum      <= 8'h00;
        end else if (msg_byte_valid) begin
            byte_idx <= last_byte ? 3'h0 : byte_idx + 3'h1;
            sum      <= last_byte ? 8'h00 : sum + msg_byte;
            if (byte_idx == 3'h0) begin
                cmd_new <= msg_byte;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd      <= 8'h00;
            bad_prev <= 1'b0;
        end else if (last_byte && !msg_start) begin
            bad_prev <= !sum_ok;
            if (sum_ok) begin
                cmd <= cmd_new;
            end
        end
    end

    // ==========================================================
    // Self-test request and health merge
    logic test_on;
    logic por_fault;
    logic any_fail;

    assign test_on = mode_sync[1] ? cmd[`GHM_CMD_TEST_BIT]
                                  : !test_sync[1];
    assign por_fault = parity_fault || trim_fault;
    assign any_fail  = por_fault || !settled || drive_high || level_low
                     || sat_fail || quad_fail;

    // Health is registered, so it lags its causes by one edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            health_ok <= 1'b0;
        end else begin
            health_ok <= !(any_fail || test_on);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_byte <= '0;
        end else begin
            status_byte.fail     <= any_fail || test_on;
            status_byte.msg_type <= `GHM_ST_TYPE_RATE;
            status_byte.bad_prev <= bad_prev;
            status_byte.test_on  <= test_on;
            status_byte.code     <= `GHM_ST_CODE_OK;
        end
    end

    // ==========================================================
    // Rate path with saturating self-test offset
    logic [`GHM_RATE_W:0]   rate_sum;
    logic [`GHM_RATE_W-1:0] rate_next;

    assign rate_sum = {rate_in[`GHM_RATE_W-1], rate_in} + (`GHM_RATE_W+1)'(OFFSET);

    // The offset is positive, so only a positive overflow can occur; it clamps.
    always_comb begin
        if (rate_sum[`GHM_RATE_W] != rate_sum[`GHM_RATE_W-1]) begin
            rate_next = {1'b0, {(`GHM_RATE_W-1){1'b1}}};
        end else begin
            rate_next = rate_sum[`GHM_RATE_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_out <= '0;
        end else begin
            rate_out <= test_on ? rate_next : rate_in;
        end
    end

    // ==========================================================
    // APB read side
    logic mapped;

    always_comb begin
        unique case (paddr)
            `GHM_REG_STATUS, `GHM_REG_DRIVE_HI, `GHM_REG_LEVEL_LO,
            `GHM_REG_DEMOD_MAX, `GHM_REG_QUAD_MAX, `GHM_REG_CMD: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Read data is loaded in the setup cycle, so it stands through the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `GHM_REG_STATUS: prdata <= {24'h0, settled, boot_done, trim_fault,
                                            parity_fault, test_on, bad_prev,
                                            mode_sync[1], health_ok};
                `GHM_REG_DRIVE_HI:  prdata <= 32'(drive_hi);
                `GHM_REG_LEVEL_LO:  prdata <= 32'(level_lo);
                `GHM_REG_DEMOD_MAX: prdata <= 32'(demod_max);
                `GHM_REG_QUAD_MAX:  prdata <= 32'(quad_max);
                `GHM_REG_CMD:       prdata <= {24'h0, cmd};
                default:            prdata <= 32'h0;
            endcase
        end
    end

    // ==========================================================
    // Assertions
    sequence s_bad_msg;
        last_byte && !msg_start && !sum_ok;
    endsequence
    sequence s_good_msg;
        last_byte && !msg_start && sum_ok;
    endsequence

    a_health_any_fail: assert property (any_fail |=> !health_ok)
        else $error("health high after a failing check");
    a_health_all_pass: assert property (!any_fail && !test_on |=> health_ok)
        else $error("health low with all checks passing");
    a_test_holds_low: assert property (test_on [*2] |=> !health_ok && status_byte.fail)
        else $error("self-test did not hold health low");
    a_por_latched: assert property ($rose(parity_fault || trim_fault)
        |=> !health_ok [*8])
        else $error("power-up fault did not stay latched");
    a_settle_hold: assert property (!settled |=> !health_ok)
        else $error("health high before loops settled");

    a_bad_checksum: assert property (s_bad_msg |=> bad_prev && cmd == $past(cmd))
        else $error("bad checksum not flagged or command changed");
    a_good_checksum: assert property (s_good_msg
        |=> !bad_prev && cmd == $past(cmd_new))
        else $error("good checksum did not load the command");

    a_offset_applied: assert property (test_on && !rate_sum[`GHM_RATE_W]
        && !rate_sum[`GHM_RATE_W-1]
        |=> rate_out == $past(rate_sum[`GHM_RATE_W-1:0]))
        else $error("self-test offset missing on rate");
    a_offset_clamped: assert property (test_on && !rate_sum[`GHM_RATE_W]
        && rate_sum[`GHM_RATE_W-1] |=> rate_out == {1'b0, {(`GHM_RATE_W-1){1'b1}}})
        else $error("self-test offset did not clamp at full scale");
    a_offset_removed: assert property (!test_on |=> rate_out == $past(rate_in))
        else $error("rate offset left after self-test removed");

    a_digital_cmd_bit: assert property (mode_sync[1] && cmd[`GHM_CMD_TEST_BIT]
        |=> status_byte.test_on)
        else $error("command bit 6 did not enable self-test");
    a_analog_pin_low: assert property (!mode_sync[1] && !test_sync[1]
        |=> status_byte.test_on && !health_ok)
        else $error("low request pin did not enable self-test");
    a_fail_bit_set: assert property (drive_high || level_low
        || quad_fail || sat_fail |=> status_byte.fail)
        else $error("status fail bit clear after a failing check");

    a_drive_limit: assert property (mon.agc_drive > drive_hi |=> !health_ok)
        else $error("drive above limit did not fail health");
    a_level_limit: assert property (mon.agc_level < level_lo |=> !health_ok)
        else $error("level below limit did not fail health");
    a_sat_pin_fail: assert property (demod_sat |=> !health_ok && status_byte.fail)
        else $error("saturation did not fail health");
    a_quad_limit: assert property (mon.quad_amp > quad_max |=> !health_ok)
        else $error("quadrature above limit did not fail health");

endmodule : ghm_monitor

//--- sim/ghm_cal_model.sv
// Calibration memory and trim converter model for the health monitor bench.
// Assumes a read is answered one cycle after cal_rd; faults are set by the bench.
`timescale 1ns/1ps

module ghm_cal_model #(
    parameter int CAL_DEPTH = 4,
    parameter int CAL_W     = 8
) (
    // Clock and fault controls.
    input  wire logic                         pclk,
    input  wire logic                         bad_parity,
    input  wire logic                         bad_trim,
    // Calibration memory.
    input  wire logic                         cal_rd,
    input  wire logic [$clog2(CAL_DEPTH)-1:0] cal_addr,
    output logic      [CAL_W:0]               cal_word,
    // Trim converter.
    input  wire logic                         trim_load,
    input  wire logic [CAL_W-1:0]             trim_code,
    output logic      [CAL_W-1:0]             trim_echo
);
    logic [CAL_W-1:0] data;

    assign data = CAL_W'(37 * cal_addr + 90);

    // Between reads the word inverts every cycle, so a sample one cycle late is caught.
    always_ff @(posedge pclk) begin
        if (cal_rd)
            cal_word <= {^data ^ bad_parity, data};
        else
            cal_word <= ~cal_word;
    end

    always_ff @(posedge pclk) begin
        if (trim_load)
            trim_echo <= bad_trim ? ~trim_code : trim_code;
    end
endmodule : ghm_cal_model

//--- sim/gyro_health_monitor_tb.sv
// Self-checking bench of the health monitor top with a calibration model.
// Assumes ghm_consts.svh on the include path and the package compiled first.
`timescale 1ns/1ps
`include "ghm_consts.svh"

module gyro_health_monitor_tb;
    // ==========
    // Signals
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic                 test_req_n, digital_mode, health_ok, demod_sat, msg_start;
    logic                 msg_byte_valid, cal_rd, trim_load, bad_parity, bad_trim, err;
    logic [7:0]           paddr, msg_byte, trim_code, trim_echo;
    logic [31:0]          pwdata, prdata, rd;
    logic [15:0]          rate_in, rate_out;
    logic [8:0]           cal_word;
    logic [1:0]           cal_addr;
    logic [11:0]          lim;
    logic [11:0]          rst_tab [4] = '{12'hf00, 12'h100, 12'hfc0, 12'h400};
    ghm_pkg::ghm_mon_s    mon, m;
    ghm_pkg::ghm_status_s status_byte;
    int                   errors, num_checks;

    always #12.5 pclk = ~pclk;

    ghm_monitor #(.SETTLE_CYC(8), .CAL_DEPTH(4), .CAL_W(8)) dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .test_req_n, .digital_mode, .health_ok, .mon, .demod_sat, .rate_in,
        .rate_out, .msg_start, .msg_byte_valid, .msg_byte, .status_byte, .cal_rd,
        .cal_addr, .cal_word, .trim_load, .trim_code, .trim_echo);
    ghm_cal_model #(.CAL_DEPTH(4), .CAL_W(8)) cal_u (
        .pclk, .bad_parity, .bad_trim, .cal_rd, .cal_addr, .cal_word, .trim_load,
        .trim_code, .trim_echo);

    // ==========
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            summarize();
        end
    endtask : apb

    task automatic wait_h(input logic v);
        int n;
        n = 0;
        while (health_ok !== v && n < 400) begin
            @(posedge pclk);
            n++;
        end
        check(32'(health_ok), 32'(v));
        if (n >= 400)
            summarize();
    endtask : wait_h

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        cyc(5);
        presetn <= 1'b1;
    endtask : do_reset

    // Byte 0 of the loop is the start pulse; bytes 1..6 form the message.
    task automatic send_msg(input logic [7:0] cmd, input logic bad);
        logic [7:0] b, sum;
        sum = 8'h00;
        for (int i = 0; i < 7; i++) begin
            b = (i == 1) ? cmd : 8'($urandom);
            if (i == 6)
                b = ~sum ^ {7'h00, bad};
            if (i > 0 && i < 6)
                sum = sum + b;
            @(posedge pclk);
            msg_start      <= (i == 0);
            msg_byte_valid <= (i > 0);
            msg_byte       <= b;
        end
        @(posedge pclk);
        msg_byte_valid <= 1'b0;
        cyc(6);
    endtask : send_msg

    function automatic logic [31:0] exp_st(input logic f, input logic b, input logic t);
        return {24'h0, f, 2'b00, b, t, 3'b001};
    endfunction : exp_st

    // ==========
    // Sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, demod_sat, msg_start, msg_byte_valid} = '0;
        {paddr, pwdata, msg_byte, rate_in, bad_parity, bad_trim, digital_mode} = '0;
        test_req_n = 1'b1;
        mon        = {12'hf00, 12'h100, 12'hfc0, 12'h400};
        errors     = 0;
        num_checks = 0;
        void'($urandom(96));
        do_reset();
        cyc(10);
        check(32'(health_ok), 32'h0);
        wait_h(1'b1);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0000_00c1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i + 4), 32'h0);
            check(rd, {20'h0, rst_tab[i]});
        end
        apb(1'b0, 8'h18, 32'h0);
        check({rd[31:1], err}, 32'h1);
        $display("start-up and registers done");
        lim = 12'($urandom_range(12'hffe, 12'h800));
        apb(1'b1, 8'h04, {20'($urandom), lim});
        apb(1'b0, 8'h04, 32'h0);
        check(rd, {20'h0, lim});
        for (int i = 0; i < 5; i++) begin
            m = {lim, 12'h100, 12'hfc0, 12'h400};
            mon       <= m;
            demod_sat <= 1'b0;
            cyc(1);
            wait_h(1'b1);
            if (i == 0) m.agc_drive = lim + 12'h1;
            if (i == 1) m.agc_level = 12'h0ff;
            if (i == 2) m.demod_amp = 12'hfc1;
            if (i == 3) m.quad_amp = 12'h401;
            mon       <= m;
            demod_sat <= (i == 4);
            cyc(2);
            #1;
            check(32'(health_ok), 32'h0);
            check(32'(status_byte.fail), 32'h1);
        end
        $display("monitor faults done");
        @(posedge pclk);
        mon        <= {lim, 12'h100, 12'hfc0, 12'h400};
        demod_sat  <= 1'b0;
        rate_in    <= 16'($urandom_range(2000));
        test_req_n <= 1'b0;
        cyc(6);
        check(32'(health_ok), 32'h0);
        check(32'(rate_out), 32'(rate_in + 16'(`GHM_ST_RATE_DPS * `GHM_LSB_PER_DPS)));
        rate_in    <= 16'h7f00;
        cyc(3);
        check(32'(rate_out), 32'h7fff);
        test_req_n <= 1'b1;
        wait_h(1'b1);
        check(32'(rate_out), 32'(rate_in));
        $display("pin self-test done");
        digital_mode <= 1'b1;
        send_msg(8'h40, 1'b0);
        check(32'(status_byte), exp_st(1'b1, 1'b0, 1'b1));
        check(32'(health_ok), 32'h0);
        send_msg(8'h00, 1'b1);
        check(32'(status_byte), exp_st(1'b1, 1'b1, 1'b1));
        apb(1'b0, 8'h14, 32'h0);
        check(rd, 32'h40);
        repeat (2) send_msg(8'h30, 1'b0);
        wait_h(1'b1);
        check(32'(status_byte), exp_st(1'b0, 1'b0, 1'b0));
        $display("command self-test done");
        for (int f = 0; f < 2; f++) begin
            bad_parity <= (f == 0);
            bad_trim   <= (f == 1);
            do_reset();
            cyc(100);
            check(32'(health_ok), 32'h0);
            apb(1'b0, 8'h00, 32'h0);
            check(32'(rd[5:4]), (f == 0) ? 32'h1 : 32'h2);
            bad_parity <= 1'b0;
            bad_trim   <= 1'b0;
            cyc(100);
            check(32'(health_ok), 32'h0);
        end
        $display("boot faults done");
        summarize();
    end
endmodule : gyro_health_monitor_tb
